//--- design/pdn_pkg.sv
// Package with register map, field positions and counting constants of the divider.
package pdn_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] PDN_OFF_CTRL = 12'h000;
  localparam logic [11:0] PDN_OFF_PRESET = 12'h004;
  localparam logic [11:0] PDN_OFF_STATUS = 12'h008;
  localparam logic [11:0] PDN_OFF_COUNT = 12'h00C;

  // Control fields and reset values.
  localparam int PDN_CTRL_SEL_A = 0;
  localparam int PDN_CTRL_SEL_B = 1;
  localparam int PDN_CTRL_SEL_C = 2;
  localparam int PDN_CTRL_LATCH = 3;
  localparam logic [3:0] PDN_CTRL_RESET = 4'h0;
  localparam logic [15:0] PDN_PRESET_RESET = 16'h0000;

  // Status fields.
  localparam int PDN_STAT_OUT = 0;
  localparam int PDN_STAT_ARMED = 1;
  localparam int PDN_STAT_MP = 2;
  localparam int PDN_STAT_PEND = 3;

  // Count snapshot fields: first [3:0], decades [15:4], last [18:16].
  localparam int PDN_CNT_FIRST_LSB = 0;
  localparam int PDN_CNT_DEC_LSB = 4;
  localparam int PDN_CNT_LAST_LSB = 16;

  // ---------------------------------------------------------------
  // Counting constants (top value = modulus minus one)
  // ---------------------------------------------------------------
  localparam logic [3:0] PDN_DECADE_TOP = 4'h9;
  localparam logic [3:0] PDN_DIV2_FIRST_TOP = 4'h1;
  localparam logic [3:0] PDN_DIV4_FIRST_TOP = 4'h3;
  localparam logic [3:0] PDN_DIV5_FIRST_TOP = 4'h4;
  localparam logic [3:0] PDN_DIV8_FIRST_TOP = 4'h7;
  localparam logic [3:0] PDN_DIV10_FIRST_TOP = 4'h9;
  localparam logic [2:0] PDN_DIV2_LAST_TOP = 3'h7;
  localparam logic [2:0] PDN_DIV4_LAST_TOP = 3'h3;
  localparam logic [2:0] PDN_DIV5_LAST_TOP = 3'h1;
  localparam logic [2:0] PDN_DIV8_LAST_TOP = 3'h1;
  localparam logic [2:0] PDN_DIV10_LAST_TOP = 3'h0;

  // Counting modes, one-hot.
  typedef enum logic [5:0] {
    PDN_MODE_PRESET = 6'b000001,
    PDN_MODE_DIV2 = 6'b000010,
    PDN_MODE_DIV4 = 6'b000100,
    PDN_MODE_DIV5 = 6'b001000,
    PDN_MODE_DIV8 = 6'b010000,
    PDN_MODE_DIV10 = 6'b100000
  } pdn_mode_t;

endpackage

//--- design/pdn_ctrl_if.sv
// Interface between the register slave and the counter core.
`timescale 1ns/100ps
interface pdn_ctrl_if;
  logic mode_sel_a;
  logic mode_sel_b;
  logic mode_sel_c;
  logic latch_en;
  logic [15:0] preset_bits;
  logic div_out;
  logic armed;
  logic master_preset_mode;
  logic pending;
  logic [18:0] count;

  modport regs (
    output mode_sel_a, mode_sel_b, mode_sel_c, latch_en, preset_bits,
    input div_out, armed, master_preset_mode, pending, count
  );
  modport core (
    input mode_sel_a, mode_sel_b, mode_sel_c, latch_en, preset_bits,
    output div_out, armed, master_preset_mode, pending, count
  );
endinterface

//--- design/pdn_decade.sv
// One presettable BCD down-counting decade with borrow chaining.
`timescale 1ns/100ps
module pdn_decade (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Load and count
  input wire logic load,
  input wire logic [3:0] load_val,
  input wire logic borrow_in,
  // State
  output logic [3:0] value,
  output logic borrow_out
);

  typedef struct packed {
    logic [3:0] digit;
  } pdn_decade_t;

  pdn_decade_t st;
  pdn_decade_t next_st;

  // Borrow ripples on when this digit underflows; combinational so a chain stays in step.
  assign borrow_out = borrow_in & (st.digit == 4'h0);
  assign value = st.digit;

  // Load wins over counting; a jammed value above nine simply counts down through it.
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.digit = load_val;
    end else if (borrow_in) begin
      if (st.digit == 4'h0) begin
        next_st.digit = pdn_pkg::PDN_DECADE_TOP;
      end else begin
        next_st.digit = st.digit - 4'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // pdn_decade

//--- design/pdn_apb_regs.sv
// APB slave holding control and preset words and showing counter state.
`timescale 1ns/100ps
module pdn_apb_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  pdn_ctrl_if.regs ctl
);

  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] preset;
    logic [31:0] rdata;
  } pdn_regs_t;

  pdn_regs_t st;
  pdn_regs_t next_st;
  logic [31:0] read_word;
  logic mapped;

  // Address decode; unmapped addresses read zero and answer with an error.
  always_comb begin
    read_word = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == pdn_pkg::PDN_OFF_CTRL) begin
      read_word = {28'h000_0000, st.ctrl};
    end else if (paddr == pdn_pkg::PDN_OFF_PRESET) begin
      read_word = {16'h0000, st.preset};
    end else if (paddr == pdn_pkg::PDN_OFF_STATUS) begin
      read_word[pdn_pkg::PDN_STAT_OUT] = ctl.div_out;
      read_word[pdn_pkg::PDN_STAT_ARMED] = ctl.armed;
      read_word[pdn_pkg::PDN_STAT_MP] = ctl.master_preset_mode;
      read_word[pdn_pkg::PDN_STAT_PEND] = ctl.pending;
    end else if (paddr == pdn_pkg::PDN_OFF_COUNT) begin
      read_word = {13'h0000, ctl.count};
    end else begin
      mapped = 1'b0;
    end
  end

  // Zero wait states: read data is caught in the setup cycle so it comes from a flop.
  always_comb begin
    next_st = st;
    if (psel && !penable) begin
      next_st.rdata = read_word;
    end
    if (psel && penable && pwrite) begin
      if (paddr == pdn_pkg::PDN_OFF_CTRL) begin
        next_st.ctrl = pwdata[3:0];
      end else if (paddr == pdn_pkg::PDN_OFF_PRESET) begin
        next_st.preset = pwdata[15:0];
      end
    end
  end

  // State register; reset selects master preset so the counter initialises.
  always_ff @(posedge clk) begin
    if (srst) begin
      st.ctrl <= pdn_pkg::PDN_CTRL_RESET;
      st.preset <= pdn_pkg::PDN_PRESET_RESET;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st.rdata;
  assign ctl.mode_sel_a = st.ctrl[pdn_pkg::PDN_CTRL_SEL_A];
  assign ctl.mode_sel_b = st.ctrl[pdn_pkg::PDN_CTRL_SEL_B];
  assign ctl.mode_sel_c = st.ctrl[pdn_pkg::PDN_CTRL_SEL_C];
  assign ctl.latch_en = st.ctrl[pdn_pkg::PDN_CTRL_LATCH];
  assign ctl.preset_bits = st.preset;

endmodule // pdn_apb_regs

//--- design/pdn_divider.sv
// Top of the programmable divide-by-N down-counter with its APB register slave.
//
// Notes on behaviour
// - Output pulses once every N clocks, N from 3 to 15,999.
// - Starting count is loaded from sixteen preset bits covering all sections.
// - Mode selects set first and last moduli; first wrap decrements upper sections.
// - Modes HHH/LHH/HLH/LLH/HHL give 2/4/5/8/10 first, 8/4/2/2/1 last.
// - In divide-by-ten mode bits 1 to 4 load first; no last section.
// - Preset bits 1 to 4 split between first and last sections by mode.
// - Three cascaded BCD decades load from preset bits 5 to 16.
// - Decades accept jam values up to fifteen, keeping decimal place values.
// - Ratio is first modulus times upper value plus first section preset.
// - Largest design N is 9999 for modes 5 and 10, else 15,999.
// - With b and c low the counter holds the preset value.
// - First edge after preset only arms; countdown starts on the second.
// - A pulse due within two clocks of entering preset still appears.
// - Without preset the jam value reloads when the pulse appears.
// - Latch enable high holds the output high after a pulse.
// - Latch enable low gives a pulse exactly one clock wide.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module pdn_divider (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Divided output
  output logic DIV_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  // First section, last section, divide-by-two memory, arming flop, pending pulse
  // and the output.
  typedef struct packed {
    logic [3:0] first;
    logic [2:0] last;
    logic by_two;
    logic armed;
    logic pend;
    logic out;
  } pdn_core_t;

  pdn_core_t st;
  pdn_core_t next_st;

  pdn_ctrl_if ctl ();

  pdn_pkg::pdn_mode_t mode;
  logic master_preset_mode;
  logic [3:0] first_top;
  logic [2:0] last_top;
  logic [3:0] first_jam;
  logic [2:0] last_jam;
  logic [15:0] preset_bits;
  logic [3:0] dec_val [3];
  logic [3:0] dec_borrow;
  logic upper_zero;
  logic upper_one;
  logic count_en;
  logic load;
  logic hit;
  logic fire;
  logic first_wrap;

  assign preset_bits = ctl.preset_bits;

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------

  // Mode selects, latch enable and the jam word all arrive from software.
  pdn_apb_regs u_regs (
    .clk(SYS_CLK),
    .srst(SRST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .ctl(ctl.regs)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------

  // preset detect.
  // Both b and c low means master preset whatever a says.
  assign master_preset_mode = ~ctl.mode_sel_b & ~ctl.mode_sel_c;

  // mode truth table.
  // The pattern a low, b high, c low is not a listed mode; it runs as divide by ten,
  // which keeps every jam bit meaningful rather than freezing the counter.
  always_comb begin
    mode = pdn_pkg::PDN_MODE_PRESET;
    case ({ctl.mode_sel_a, ctl.mode_sel_b, ctl.mode_sel_c})
      3'b111: begin
        mode = pdn_pkg::PDN_MODE_DIV2;
      end
      3'b011: begin
        mode = pdn_pkg::PDN_MODE_DIV4;
      end
      3'b101: begin
        mode = pdn_pkg::PDN_MODE_DIV5;
      end
      3'b001: begin
        mode = pdn_pkg::PDN_MODE_DIV8;
      end
      3'b110, 3'b010: begin
        mode = pdn_pkg::PDN_MODE_DIV10;
      end
      default: begin
        mode = pdn_pkg::PDN_MODE_PRESET;
      end
    endcase
  end

  // section tops set maxima.
  // Bit 1 is the least significant; the bits the first section does not need go
  // to the last section. In preset the divide-by-ten split is used, but this only
  // matters for reading back: the arming edge reloads with the real mode's split.
  always_comb begin
    first_top = pdn_pkg::PDN_DIV10_FIRST_TOP;
    last_top = pdn_pkg::PDN_DIV10_LAST_TOP;
    first_jam = preset_bits[3:0];
    last_jam = 3'h0;
    case (mode)
      pdn_pkg::PDN_MODE_DIV2: begin
        first_top = pdn_pkg::PDN_DIV2_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV2_LAST_TOP;
        first_jam = {3'h0, preset_bits[0]};
        last_jam = preset_bits[3:1];
      end
      pdn_pkg::PDN_MODE_DIV4: begin
        first_top = pdn_pkg::PDN_DIV4_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV4_LAST_TOP;
        first_jam = {2'h0, preset_bits[1:0]};
        last_jam = {1'h0, preset_bits[3:2]};
      end
      pdn_pkg::PDN_MODE_DIV5: begin
        first_top = pdn_pkg::PDN_DIV5_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV5_LAST_TOP;
        first_jam = {1'h0, preset_bits[2:0]};
        last_jam = {2'h0, preset_bits[3]};
      end
      pdn_pkg::PDN_MODE_DIV8: begin
        first_top = pdn_pkg::PDN_DIV8_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV8_LAST_TOP;
        first_jam = {1'h0, preset_bits[2:0]};
        last_jam = {2'h0, preset_bits[3]};
      end
      pdn_pkg::PDN_MODE_DIV10: begin
        first_top = pdn_pkg::PDN_DIV10_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV10_LAST_TOP;
        first_jam = preset_bits[3:0];
        last_jam = 3'h0;
      end
      default: begin
        first_top = pdn_pkg::PDN_DIV10_FIRST_TOP;
        last_top = pdn_pkg::PDN_DIV10_LAST_TOP;
        first_jam = preset_bits[3:0];
        last_jam = 3'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Count control
  // ---------------------------------------------------------------

  // The whole count stands at one when the first section holds one and every
  // upper section is empty; that is the last state before the pulse.
  assign upper_zero = (dec_val[0] == 4'h0) & (dec_val[1] == 4'h0)
                    & (dec_val[2] == 4'h0) & (st.last == 3'h0);

  // In divide-by-two mode a count of two is an empty first section over an upper
  // value of one, so the pending check needs this pattern as well.
  assign upper_one = (dec_val[0] == 4'h1) & (dec_val[1] == 4'h0)
                   & (dec_val[2] == 4'h0) & (st.last == 3'h0);

  assign count_en = st.armed & ~master_preset_mode;

  // terminal count.
  // Armed still holds on the edge that enters preset, so a count of one there
  // fires its pulse on time as well.
  assign hit = st.armed & (st.first == 4'h1) & upper_zero;

  assign fire = hit | st.pend;

  // hold during preset.
  // Loading while unarmed also covers the arming edge, which picks up the split
  // of the newly selected mode.
  assign load = master_preset_mode | ~st.armed | hit;

  assign first_wrap = st.first == 4'h0;
  assign dec_borrow[0] = count_en & ~load & first_wrap;

  // ---------------------------------------------------------------
  // Intermediate decades
  // ---------------------------------------------------------------

  // jam up to fifteen.
  // Decade k takes preset bits 5+4k to 8+4k, lowest place value first.
  for (genvar k = 0; k < 3; k++) begin : g_decade
    pdn_decade u_decade (
      .clk(SYS_CLK),
      .srst(SRST),
      .load(load),
      .load_val(preset_bits[4*k+4 +: 4]),
      .borrow_in(dec_borrow[k]),
      .value(dec_val[k]),
      .borrow_out(dec_borrow[k+1])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // ratio arithmetic.
  // Counting the first section down through its modulus and borrowing into the
  // upper sections walks every value from the jam count down to one, so the
  // ratio is the modulus times the upper value plus the first preset.
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.first = first_jam;
      next_st.last = last_jam;
    end else if (count_en) begin
      if (first_wrap) begin
        next_st.first = first_top;
      end else begin
        next_st.first = st.first - 4'h1;
      end
      if (dec_borrow[3]) begin
        if (st.last == 3'h0) begin
          next_st.last = last_top;
        end else begin
          next_st.last = st.last - 3'h1;
        end
      end
    end
    next_st.armed = ~master_preset_mode;
    // The mode already reads as preset on the entry edge, so the divide-by-two memory of the counting mode is kept.
    if (!master_preset_mode) begin
      next_st.by_two = mode == pdn_pkg::PDN_MODE_DIV2;
    end
    // count of two at preset entry.
    // One edge later the count would have hit one, so the pulse is kept pending.
    next_st.pend = st.armed & master_preset_mode
                 & (((st.first == 4'h2) & upper_zero)
                 | (st.by_two & (st.first == 4'h0) & upper_one));
    next_st.out = fire | (ctl.latch_en & st.out);
  end

  // rising edge state.
  // A synchronous reset leaves the counter unarmed; it reloads and arms on the
  // first edges that software leaves in a counting mode.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs and status
  // ---------------------------------------------------------------

  // Status and a live snapshot of every section go back to the register slave.
  assign DIV_OUT = st.out;
  assign ctl.div_out = st.out;
  assign ctl.armed = st.armed;
  assign ctl.master_preset_mode = master_preset_mode;
  assign ctl.pending = st.pend;
  assign ctl.count = {st.last, dec_val[2], dec_val[1], dec_val[0], st.first};

endmodule // pdn_divider

//--- verification/pdn_apb_master.sv
// APB master model standing in for the controller that drives the divider.
`timescale 1ns/100ps
module pdn_apb_master (
  // Clock
  input wire logic clk,
  // Request side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer side
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero.
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
  end

  // One transfer; the request stands until pready is sampled high or 64 further edges pass.
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    rdata = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk so that no stale value can be mistaken for a request.
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask
endmodule // pdn_apb_master

//--- verification/pdn_divider_monitor.sv
// Port checker of the divider, bound to its top module.
`timescale 1ns/100ps
module pdn_divider_monitor (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Divided output
  input wire logic DIV_OUT
);
  logic [3:0] ctrl;
  logic [2:0] mp_cnt;
  logic mapped;
  logic acc;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  // Decode of the four mapped words and of a completing access.
  assign mapped = (PADDR == 12'h000) || (PADDR == 12'h004) || (PADDR == 12'h008)
                  || (PADDR == 12'h00C);
  assign acc = PSEL && PENABLE;

  // Shadow of the control word and a count of quiet preset cycles.
  // A latched output may stand high in preset, so latch enable restarts the count.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl <= 4'h0;
      mp_cnt <= 3'h0;
    end else begin
      if (acc && PWRITE && PADDR == 12'h000) begin
        ctrl <= PWDATA[3:0];
      end
      if (ctrl[2:1] != 2'b00 || ctrl[3]) begin
        mp_cnt <= 3'h0;
      end else if (mp_cnt != 3'h7) begin
        mp_cnt <= mp_cnt + 3'h1;
      end
    end
  end

  // -------------------------------------------------------------
  // Bus answers
  // -------------------------------------------------------------
  a_ready_zero_wait: assert property (PREADY == acc)
    else $error("pready does not follow the access phase");
  a_err_unmapped: assert property (acc && !mapped |-> PSLVERR)
    else $error("unmapped access not flagged");
  a_err_only_unmapped: assert property (PSLVERR |-> acc && !mapped)
    else $error("error flagged on a mapped word or outside access");
  a_unmapped_read_zero: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
    else $error("unmapped read returned data");
  a_status_snapshot: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 12'h008
                                      |=> PRDATA[0] == $past(DIV_OUT))
    else $error("status does not show the output at setup");

  // -------------------------------------------------------------
  // Divided output
  // -------------------------------------------------------------
  a_reset_out_low: assert property ($past(SRST) |-> !DIV_OUT)
    else $error("output high straight after reset");
  a_pulse_one_wide: assert property ($rose(DIV_OUT) && !ctrl[3] && !$past(ctrl[3])
                                     |=> !DIV_OUT)
    else $error("unlatched pulse wider than one clock");
  a_latch_holds: assert property (DIV_OUT && ctrl[3] |=> DIV_OUT)
    else $error("latched output fell while latch enabled");
  a_preset_quiet: assert property (mp_cnt >= 3'h5 |-> !DIV_OUT)
    else $error("output pulsed in master preset");
endmodule // pdn_divider_monitor

bind pdn_divider pdn_divider_monitor mon_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .DIV_OUT(DIV_OUT));

//--- verification/pdn_divider_tb.sv
// Self-checking testbench of the divide-by-N counter.
`timescale 1ns/100ps
module pdn_divider_tb;
  typedef struct {logic [3:0] ctrl; logic [15:0] jam; int n;} pdn_row_t;
  logic SYS_CLK;
  logic SRST;
  logic psel, penable, pwrite, pready, pslverr, div_out;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic err;
  int k;
  int miscompares;
  int compares;
  pdn_row_t rows [7];
  pdn_row_t late [3];

  pdn_apb_master mst_u (.clk(SYS_CLK), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pdn_divider dut_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DIV_OUT(div_out));

  // Free-running 250 MHz clock.
  always #2 SYS_CLK = ~SYS_CLK;

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("Compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    logic ok;
    mst_u.xfer(wr, a, wd, rd, err, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: bus transfer hung", $time);
      wrap_up();
    end
  endtask

  // Counts edges up to and including the one after which the output is high.
  task automatic wait_pulse;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      k++;
    end while (div_out !== 1'b1 && k < 20000);
    if (div_out !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no output pulse", $time);
      wrap_up();
    end
  endtask

  // Master preset with a new jam value; the counter must freeze on it.
  task automatic load(input logic [15:0] jam);
    apb(1'b1, pdn_pkg::PDN_OFF_CTRL, 32'h0);
    apb(1'b1, pdn_pkg::PDN_OFF_PRESET, {16'h0, jam});
    repeat (3) begin
      @(posedge SYS_CLK);
      #1;
      chk(div_out, 32'h0, "output in preset");
    end
    apb(1'b0, pdn_pkg::PDN_OFF_COUNT, 32'h0);
    chk(rd, {16'h0, jam}, "jammed count");
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    SRST = 1'b1;
    miscompares = 0;
    compares = 0;
    rows = '{'{4'h4, 16'h0003, 3}, '{4'h7, 16'h0023, 2005}, '{4'h6, 16'h01F2, 102},
             '{4'h5, 16'h0134, 69}, '{4'h4, 16'h0018, 8008}, '{4'h3, 16'h0029, 29},
             '{4'h3, 16'h1000, 1000}};
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    // Every mode, each entered from master preset.
    foreach (rows[i]) begin
      load(rows[i].jam);
      apb(1'b1, pdn_pkg::PDN_OFF_CTRL, {28'h0, rows[i].ctrl});
      wait_pulse();
      chk(k, rows[i].n + 1, "first pulse");
      wait_pulse();
      chk(k, rows[i].n, "division ratio");
      wait_pulse();
      chk(k, rows[i].n, "reload period");
      $display("Test row %0d done", i);
    end
    // Latched output stands high until latch enable drops.
    load(16'h0003);
    apb(1'b1, pdn_pkg::PDN_OFF_CTRL, 32'h0000000C);
    wait_pulse();
    repeat (6) begin
      @(posedge SYS_CLK);
      #1;
      chk(div_out, 32'h1, "latched output");
    end
    apb(1'b0, pdn_pkg::PDN_OFF_STATUS, 32'h0);
    chk(rd[0], 32'h1, "status output bit");
    apb(1'b1, pdn_pkg::PDN_OFF_CTRL, 32'h0);
    repeat (5) @(posedge SYS_CLK);
    #1;
    chk(div_out, 32'h0, "latch released");
    $display("Test latch done");
    // Preset entered one or two clocks before a due pulse, divide by two included.
    late = '{'{4'h4, 16'h0004, 4}, '{4'h4, 16'h0005, 5}, '{4'h7, 16'h0021, 5}};
    foreach (late[i]) begin
      load(late[i].jam);
      apb(1'b1, pdn_pkg::PDN_OFF_CTRL, {28'h0, late[i].ctrl});
      wait_pulse();
      wait_pulse();
      // The preset write lands three edges after a pulse, so the next is n - 3 later.
      apb(1'b1, pdn_pkg::PDN_OFF_CTRL, 32'h0);
      wait_pulse();
      chk(k, late[i].n - 3, "pulse at preset entry");
    end
    $display("Test late preset done");
    // Unmapped word and a write to a read-only word.
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, pdn_pkg::PDN_OFF_STATUS, 32'hFFFFFFFF);
    chk(err, 32'h0, "read-only write");
    $display("Test bus done");
    // Second reset in mid-run restores the preset state.
    apb(1'b1, pdn_pkg::PDN_OFF_CTRL, 32'h00000004);
    SRST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    apb(1'b0, pdn_pkg::PDN_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "control after reset");
    apb(1'b0, pdn_pkg::PDN_OFF_PRESET, 32'h0);
    chk(rd, 32'h0, "preset after reset");
    #1;
    chk(div_out, 32'h0, "output after reset");
    $display("Test reset done");
    wrap_up();
  end
endmodule // pdn_divider_tb
